// *** rtl/stack_push_pop_unit.sv ***
// Purpose: stack push/pop sequencing between execution core and stack memory
// Assumes: one command at a time; memory answers each request with one MEM_ACK_I
// Notes:   VARIANT picks selector, wrap and error-code behaviour at elaboration
// How it works
// RULE1: default selector push writes two bytes only
// RULE2: alternative selector push zero-extends to operand size
// RULE3: default selector pop reads two bytes
// RULE4: alternative selector pop reads operand size
// RULE5: alternative faults on bad selector upper bytes
// RULE6: default wrapping pop writes offset zero plus index
// RULE7: alternative wrapping pop faults or writes 10000H
// RULE8: error code pushed as zero-extended four bytes
// RULE9: legacy error code two bytes, pointer minus four
// RULE10: far call checks branch before any push
// RULE11: limit or rights violation is branch fault
// RULE12: branch fault restores pre-instruction stack pointer
// RULE13: return through 16-bit gate zeroes pointer top
// RULE14: variant chosen by static parameter
`timescale 1ns/1ps
`default_nettype none
module stack_push_pop_unit
#(
	parameter stack_unit_pkg::variant_t VARIANT = stack_unit_pkg::VAR_DEFAULT // RULE14
)
(
	input  wire logic                     CLK_I,
	input  wire logic                     RST_N_I,
	input  wire logic                     CMD_VALID_I,
	input  wire stack_unit_pkg::cmd_t     CMD_I,
	output logic                          CMD_READY_O,
	output stack_unit_pkg::mem_req_t      MEM_REQ_O,
	input  wire logic                     MEM_ACK_I,
	input  wire logic [31:0]              MEM_RDATA_I,
	output logic                          DONE_O,
	output stack_unit_pkg::exc_t          EXC_O,
	output logic [31:0]                   SP_O,
	output logic [31:0]                   POP_DATA_O
);
	import stack_unit_pkg::*;

	// =====================================================================
	// helpers
	// stack pointer step that keeps the upper half on a 16-bit stack
	function automatic logic [31:0] sp_move(input logic [31:0] sp, input logic [31:0] d,
		input logic up, input logic s32);
		logic [31:0] r;
		r = up ? sp + d : sp - d;
		return s32 ? r : {sp[31:16], r[15:0]};
	endfunction : sp_move

	// segment offset seen by memory for a given pointer
	function automatic logic [31:0] ss_off(input logic [31:0] sp, input logic s32);
		return s32 ? sp : {HALF_ZERO, sp[15:0]};
	endfunction : ss_off

	// =====================================================================
	// state
	state_t      state_reg;
	cmd_t        cmd_reg;
	mem_req_t    req_reg;
	logic [31:0] sp_reg;
	logic [31:0] orig_sp_reg;
	logic        second_reg;
	logic        done_reg;
	exc_t        exc_reg;
	logic [31:0] pop_data_reg;
	logic        ready_reg;     // idle flag held in a flop of its own, so the port carries no decode

	// =====================================================================
	// decode of the latched command
	wire         op32      = cmd_reg.opsize32;
	wire         s32       = cmd_reg.stack32;
	wire         is_alt    = (VARIANT == VAR_ALT);
	wire         err_full  = (VARIANT != VAR_LEGACY);
	wire         is_sel    = (cmd_reg.op == OP_PUSH_SEL) || (cmd_reg.op == OP_POP_SEL);
	wire [31:0]  dsz       = op32 ? SIZE_DWORD : SIZE_WORD;
	wire         sel_fault = is_alt && op32 && is_sel && !cmd_reg.upper_ok;  // RULE5
	wire         br_fault  = cmd_reg.br_limit_viol | cmd_reg.br_rights_viol; // RULE11
	wire         wrap_hit  = !s32 && cmd_reg.sp_base && (op32 ?
		(sp_reg[15:0] == SP_WRAP_DWORD) : (sp_reg[15:0] == SP_WRAP_WORD));
	wire         wrap_fault = is_alt && wrap_hit && (!cmd_reg.prot_mode || !cmd_reg.ss_big); // RULE7

	// push step, lanes and data
	wire [31:0]  push_step = (cmd_reg.op == OP_PUSH_ERR) ? (s32 ? ERR_STEP : SIZE_WORD) : dsz; // RULE9
	wire [31:0]  sp_pushed = sp_move(sp_reg, push_step, 1'b0, s32);
	wire [3:0]   push_be   = (cmd_reg.op == OP_PUSH_SEL) ? ((is_alt && op32) ? BE_ALL : BE_LO16) :
		(cmd_reg.op == OP_PUSH_ERR) ? ((s32 && err_full) ? BE_ALL : BE_LO16) : // RULE8
		(op32 ? BE_ALL : BE_LO16);                                           // RULE1 RULE2
	wire [31:0]  push_data = second_reg ? cmd_reg.eip : {HALF_ZERO, cmd_reg.data[15:0]};

	// pop lanes and destination
	wire [31:0]  sp_popped = sp_move(sp_reg, dsz, 1'b1, s32);
	wire [3:0]   pop_be    = (cmd_reg.op == OP_POP_SEL) ? ((is_alt && op32) ? BE_ALL : BE_LO16) :
		(cmd_reg.op == OP_POP_MEM) ? (op32 ? BE_ALL : BE_LO16) : BE_LO16; // RULE3 RULE4
	wire [31:0]  pop_val   = MEM_RDATA_I & {{16{pop_be[3]}}, 16'hFFFF};
	wire [31:0]  dest_base = (is_alt && wrap_hit) ? SS_WRAP_BASE :                // RULE7
		(cmd_reg.sp_base ? ss_off(sp_popped, s32) : OFFSET_ZERO);              // RULE6
	wire [31:0]  pop_dest  = dest_base + cmd_reg.ea_off;

	// =====================================================================
	// sequencer
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			state_reg    <= S_IDLE;
			cmd_reg      <= '0;
			req_reg      <= '0;
			sp_reg       <= '0;
			orig_sp_reg  <= '0;
			second_reg   <= 1'b0;
			done_reg     <= 1'b0;
			exc_reg      <= EXC_NONE;
			pop_data_reg <= '0;
			ready_reg    <= 1'b1;
		end
		else
		begin
			done_reg <= 1'b0;
			unique case (state_reg)
			S_IDLE:
			begin
				if (CMD_VALID_I)
				begin
					cmd_reg     <= CMD_I;
					sp_reg      <= CMD_I.sp;
					orig_sp_reg <= CMD_I.sp;
					second_reg  <= 1'b0;
					exc_reg     <= EXC_NONE;
					ready_reg   <= 1'b0;
					state_reg   <= S_EXEC;
				end
			end
			S_EXEC:
			begin
				if (cmd_reg.op == OP_FAR_CALL && br_fault)
				begin
					exc_reg   <= EXC_BRANCH;     // RULE10
					sp_reg    <= orig_sp_reg;    // RULE12
					state_reg <= S_DONE;
				end
				else if (sel_fault || (cmd_reg.op == OP_POP_MEM && wrap_fault))
				begin
					exc_reg   <= sel_fault ? EXC_SEG : EXC_STACK; // RULE5 RULE7
					state_reg <= S_DONE;
				end
				else if (cmd_reg.op == OP_PUSH_SEL || cmd_reg.op == OP_PUSH_ERR ||
					cmd_reg.op == OP_FAR_CALL)
				begin
					sp_reg    <= sp_pushed;      // RULE1 RULE8
					req_reg   <= '{1'b1, 1'b1, ss_off(sp_pushed, s32), push_data, push_be};
					state_reg <= S_WRITE;
				end
				else
				begin
					req_reg   <= '{1'b1, 1'b0, ss_off(sp_reg, s32), 32'h0000_0000, pop_be};
					state_reg <= S_READ;
				end
			end
			S_WRITE:
			begin
				if (MEM_ACK_I && cmd_reg.op == OP_FAR_CALL && !second_reg)
				begin
					// old code selector is down, instruction pointer follows
					second_reg <= 1'b1;
					sp_reg     <= sp_pushed;
					req_reg    <= '{1'b1, 1'b1, ss_off(sp_pushed, s32), cmd_reg.eip, push_be};
				end
				else if (MEM_ACK_I)
				begin
					req_reg   <= '0;
					state_reg <= S_DONE;
				end
			end
			S_READ:
			begin
				if (MEM_ACK_I)
				begin
					pop_data_reg <= pop_val;
					if (cmd_reg.op == OP_RET_GATE16)
					begin
						sp_reg    <= {HALF_ZERO, MEM_RDATA_I[15:0]}; // RULE13
						req_reg   <= '0;
						state_reg <= S_DONE;
					end
					else if (cmd_reg.op == OP_POP_MEM)
					begin
						sp_reg    <= sp_popped;
						req_reg   <= '{1'b1, 1'b1, pop_dest, pop_val, pop_be}; // RULE6
						state_reg <= S_WRITE;
					end
					else
					begin
						sp_reg    <= sp_popped;  // RULE3 RULE4
						req_reg   <= '0;
						state_reg <= S_DONE;
					end
				end
			end
			S_DONE:
			begin
				done_reg  <= 1'b1;
				ready_reg <= 1'b1;
				state_reg <= S_IDLE;
			end
			endcase
		end
	end

	// =====================================================================
	// outputs straight from flops
	assign CMD_READY_O = ready_reg;
	assign MEM_REQ_O   = req_reg;
	assign DONE_O      = done_reg;
	assign EXC_O       = exc_reg;
	assign SP_O        = sp_reg;
	assign POP_DATA_O  = pop_data_reg;

	// =====================================================================
	// checks
	wire in_exec  = (state_reg == S_EXEC);

	sequence s_branch_refused;
		(in_exec && cmd_reg.op == OP_FAR_CALL && br_fault) ##1 (exc_reg == EXC_BRANCH);
	endsequence
	sequence s_quiet_then_done;
		(!MEM_REQ_O.valid) [*2] ##0 DONE_O;
	endsequence

	property p_sel_push_two;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(VARIANT != VAR_ALT && MEM_REQ_O.valid && MEM_REQ_O.write && cmd_reg.op == OP_PUSH_SEL)
		|-> MEM_REQ_O.be == BE_LO16;
	endproperty
	a_sel_push_two: assert property (p_sel_push_two) else $error("selector push wrote upper bytes"); // RULE1

	property p_sel_push_zero;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(is_alt && MEM_REQ_O.valid && MEM_REQ_O.write && cmd_reg.op == OP_PUSH_SEL && op32)
		|-> (MEM_REQ_O.be == BE_ALL && MEM_REQ_O.data[31:16] == HALF_ZERO);
	endproperty
	a_sel_push_zero: assert property (p_sel_push_zero) else $error("wide selector push not zeroed"); // RULE2

	property p_sel_pop_width;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(in_exec && cmd_reg.op == OP_POP_SEL && !sel_fault) |=>
		(MEM_REQ_O.valid && !MEM_REQ_O.write &&
		MEM_REQ_O.be == ((is_alt && op32) ? BE_ALL : BE_LO16));
	endproperty
	a_sel_pop_width: assert property (p_sel_pop_width) else $error("selector pop read width wrong"); // RULE3 RULE4

	property p_sel_fault;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(in_exec && is_sel && op32 && !cmd_reg.upper_ok) |=>
		(is_alt ? (exc_reg == EXC_SEG && !MEM_REQ_O.valid) : (exc_reg == EXC_NONE));
	endproperty
	a_sel_fault: assert property (p_sel_fault) else $error("selector upper byte fault wrong"); // RULE5

	property p_wrap_dest;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(state_reg == S_READ && MEM_ACK_I && cmd_reg.op == OP_POP_MEM && wrap_hit) |=>
		(MEM_REQ_O.addr == (is_alt ? SS_WRAP_BASE : OFFSET_ZERO) + cmd_reg.ea_off);
	endproperty
	a_wrap_dest: assert property (p_wrap_dest) else $error("wrapping pop destination wrong"); // RULE6 RULE7

	property p_err_push;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(in_exec && cmd_reg.op == OP_PUSH_ERR && s32) |=>
		(sp_reg == orig_sp_reg - ERR_STEP && MEM_REQ_O.data[31:16] == HALF_ZERO &&
		MEM_REQ_O.be == (VARIANT == VAR_LEGACY ? BE_LO16 : BE_ALL));
	endproperty
	a_err_push: assert property (p_err_push) else $error("error code push wrong"); // RULE8 RULE9

	property p_branch_first;
		@(posedge CLK_I) disable iff (!RST_N_I)
		s_branch_refused |-> s_quiet_then_done;
	endproperty
	a_branch_first: assert property (p_branch_first) else $error("push issued despite branch fault"); // RULE10 RULE11

	property p_branch_sp;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(DONE_O && EXC_O == EXC_BRANCH) |-> SP_O == orig_sp_reg;
	endproperty
	a_branch_sp: assert property (p_branch_sp) else $error("pointer not restored on branch fault"); // RULE12

	property p_gate16_sp;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(state_reg == S_READ && MEM_ACK_I && cmd_reg.op == OP_RET_GATE16) |=>
		(SP_O == {HALF_ZERO, $past(MEM_RDATA_I[15:0])}) ##1 DONE_O;
	endproperty
	a_gate16_sp: assert property (p_gate16_sp) else $error("gate return pointer top not zero"); // RULE13

	// selector push moves the pointer down by the operand size, low half checked
	property p_sel_push_step;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(in_exec && cmd_reg.op == OP_PUSH_SEL && !sel_fault) |=>
		(SP_O[15:0] == $past(sp_reg[15:0]) - $past(dsz[15:0]));
	endproperty
	a_sel_push_step: assert property (p_sel_push_step) else $error("selector push step wrong"); // RULE1 RULE2

	// selector pop moves the pointer up by the operand size whatever the read width
	property p_sel_pop_step;
		@(posedge CLK_I) disable iff (!RST_N_I)
		(state_reg == S_READ && MEM_ACK_I && cmd_reg.op == OP_POP_SEL) |=>
		(SP_O[15:0] == $past(sp_reg[15:0]) + $past(dsz[15:0]));
	endproperty
	a_sel_pop_step: assert property (p_sel_pop_step) else $error("selector pop step wrong"); // RULE3 RULE4
endmodule : stack_push_pop_unit
`default_nettype wire

// *** rtl/stack_unit_pkg.sv ***
// Purpose: shared types and constants of the stack push/pop unit
// Assumes: 32-bit stack pointer, stack memory addressed as stack-segment offsets
// Notes:   byte enables are relative to the addressed slot, lane 0 lowest
package stack_unit_pkg;
	// =====================================================================
	// sizes and steps
	localparam logic [31:0] SIZE_WORD     = 32'h0000_0002;
	localparam logic [31:0] SIZE_DWORD    = 32'h0000_0004;
	localparam logic [31:0] ERR_STEP      = 32'h0000_0004;
	localparam logic [31:0] OFFSET_ZERO   = 32'h0000_0000;
	localparam logic [3:0]  BE_LO16       = 4'h3;
	localparam logic [3:0]  BE_ALL        = 4'hF;
	localparam logic [15:0] HALF_ZERO     = 16'h0000;
	// =====================================================================
	// pop-to-memory wrap corner
	localparam logic [15:0] SP_WRAP_DWORD = 16'hFFFC;
	localparam logic [15:0] SP_WRAP_WORD  = 16'hFFFE;
	localparam logic [31:0] SS_WRAP_BASE  = 32'h0001_0000;
	// =====================================================================
	// enumerations
	typedef enum logic [1:0] {VAR_DEFAULT, VAR_ALT, VAR_LEGACY} variant_t;
	typedef enum logic [2:0] {OP_PUSH_SEL, OP_POP_SEL, OP_PUSH_ERR, OP_POP_MEM,
		OP_FAR_CALL, OP_RET_GATE16} op_t;
	typedef enum logic [1:0] {EXC_NONE, EXC_SEG, EXC_STACK, EXC_BRANCH} exc_t;
	typedef enum {S_IDLE, S_EXEC, S_WRITE, S_READ, S_DONE} state_t;
	// =====================================================================
	// carriers
	typedef struct packed {
		op_t         op;
		logic        opsize32;      // operand size is 32 bits
		logic        stack32;       // stack segment is 32-bit
		logic        prot_mode;     // protected mode
		logic        ss_big;        // stack segment larger than 64 Kbyte
		logic        upper_ok;      // bytes 3 and 4 within limit and on present page
		logic        sp_base;       // scale_index_base_byte names stack_pointer as base
		logic        br_limit_viol; // branch target beyond segment limit
		logic        br_rights_viol;// branch target access rights violation
		logic [31:0] sp;            // stack_pointer before the instruction
		logic [31:0] data;          // selector, error code or old code selector
		logic [31:0] eip;           // old instruction pointer for far call
		logic [31:0] ea_off;        // scaled index plus displacement
	} cmd_t;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;          // stack-segment offset
		logic [31:0] data;
		logic [3:0]  be;
	} mem_req_t;
endpackage : stack_unit_pkg

// *** test/stack_mem_model.sv ***
// Purpose: stack memory partner answering after a random delay
// Assumes: one request outstanding, held until the ack edge
// Notes:   read data is a pattern of the address; writes are logged
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire stack_unit_pkg::mem_req_t req_i,
	output logic                          ack_o,
	output logic [31:0]                   rdata_o,
	output logic [31:0]                   wr_addr_o,
	output logic [31:0]                   wr_data_o,
	output logic [3:0]                    wr_be_o,
	output logic [31:0]                   wr_count_o
);
	import stack_unit_pkg::*;
	logic [1:0] wait_reg;
	logic [7:0] rnd_reg;
	// =====================================================================
	// answer after 0..3 idle cycles; data toggles outside the ack cycle
	always @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		rnd_reg <= {rnd_reg[6:0], rnd_reg[7] ^ rnd_reg[5] ^ rnd_reg[4] ^ rnd_reg[3]};
		if (!rst_n_i)
		begin
			wait_reg <= 2'h0;
			rnd_reg <= 8'h5A;
			rdata_o <= 32'h0;
			wr_count_o <= 32'h0;
		end
		else if (req_i.valid && !ack_o)
		begin
			if (wait_reg != 2'h0)
				wait_reg <= wait_reg - 2'h1;
			else
			begin
				ack_o <= 1'b1;
				rdata_o <= {~req_i.addr[15:0], req_i.addr[7:0], req_i.addr[15:8]};
				wait_reg <= rnd_reg[1:0];
				if (req_i.write)
				begin
					wr_addr_o <= req_i.addr;
					wr_data_o <= req_i.data;
					wr_be_o <= req_i.be;
					wr_count_o <= wr_count_o + 32'h1;
				end
			end
		end
	end
endmodule : stack_mem_model
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: self-checking bench of the stack unit, all three variants side by side
// Assumes: memory partner logs the last write
// Notes:   random selector and error pushes plus wrap and far-call corners
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import stack_unit_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmd_valid = 1'b0;
	cmd_t        cmd = '0;
	logic        cmd_ready [3];
	logic        done [3];
	logic        mem_ack [3];
	mem_req_t    mem_req [3];
	exc_t        exc [3];
	logic [31:0] sp [3];
	logic [31:0] pop_data [3];
	logic [31:0] rdata [3];
	logic [31:0] wr_addr [3];
	logic [31:0] wr_data [3];
	logic [31:0] wr_count [3];
	logic [31:0] cnt [3];
	logic [3:0]  wr_be [3];
	logic [31:0] base, n, m;
	logic        alt, leg, w;
	logic [15:0] rnd = 16'h0050;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	cmd_t        c;
	// =====================================================================
	// clock, timeout and instances
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			complete_run();
		end
	end
	// one unit and one memory per variant, all fed the same commands
	for (genvar g = 0; g < 3; g++)
	begin : g_var
		stack_push_pop_unit #(.VARIANT(variant_t'(g))) u_stack_push_pop_unit
		(.CLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
			.CMD_READY_O(cmd_ready[g]), .MEM_REQ_O(mem_req[g]), .MEM_ACK_I(mem_ack[g]),
			.MEM_RDATA_I(rdata[g]), .DONE_O(done[g]), .EXC_O(exc[g]), .SP_O(sp[g]),
			.POP_DATA_O(pop_data[g]));
		stack_mem_model u_stack_mem_model
		(.clk_i(clk), .rst_n_i(rst_n), .req_i(mem_req[g]), .ack_o(mem_ack[g]),
			.rdata_o(rdata[g]), .wr_addr_o(wr_addr[g]), .wr_data_o(wr_data[g]),
			.wr_be_o(wr_be[g]), .wr_count_o(wr_count[g]));
	end
	// =====================================================================
	// helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	// memory read pattern: inverted address above, byte-swapped address below
	function automatic logic [31:0] mem_word(input logic [31:0] a);
		return {~a[15:0], a[7:0], a[15:8]};
	endfunction : mem_word
	function automatic cmd_t mk(op_t op, logic op32, logic s32, logic [31:0] p, logic [31:0] d);
		cmd_t r;
		r = '0;
		r.op = op;
		r.opsize32 = op32;
		r.stack32 = s32;
		r.upper_ok = 1'b1;
		r.sp = p;
		r.data = d;
		r.eip = ~d;
		return r;
	endfunction : mk
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic run(input cmd_t cc);
		logic       r;
		logic [2:0] seen;
		for (int v = 0; v < 3; v++)
			cnt[v] = wr_count[v];
		seen = 3'h0;
		@(posedge clk);
		cmd <= cc;
		cmd_valid <= 1'b1;
		for (int k = 0; k < 20; k++)
		begin
			#1 r = cmd_ready[0] & cmd_ready[1] & cmd_ready[2];
			@(posedge clk);
			if (r) break;
		end
		cmd_valid <= 1'b0;
		// variants finish at different cycles; wait until every one has pulsed done
		for (int k = 0; k < 60; k++)
		begin
			#1;
			for (int v = 0; v < 3; v++)
				seen[v] = seen[v] | (done[v] === 1'b1);
			if (seen == 3'h7) break;
			@(posedge clk);
		end
		for (int v = 0; v < 3; v++)
			chk(32'(seen[v]), 32'h1);
	endtask : run
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	// =====================================================================
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		// index 0 default, 1 alternative, 2 legacy
		for (int i = 0; i < 24; i++)
		begin
			rnd = lfsr_next(rnd);
			base = {16'h0001, rnd[15:1], 1'b0};
			n = rnd[0] ? SIZE_DWORD : SIZE_WORD;
			run(mk(OP_PUSH_SEL, rnd[0], 1'b1, base, {16'hBEEF, rnd}));
			for (int v = 0; v < 3; v++)
			begin
				w = (v == 1) && rnd[0];
				chk(sp[v], base - n);
				chk(wr_addr[v], base - n);
				chk(32'(wr_be[v]), w ? 32'(BE_ALL) : 32'(BE_LO16));
				chk(32'(wr_data[v][15:0]), 32'(rnd));
				if (w) chk(32'(wr_data[v][31:16]), 32'h0);
			end
			run(mk(OP_POP_SEL, rnd[0], 1'b1, base, 32'h0));
			for (int v = 0; v < 3; v++)
			begin
				m = ((v == 1) && rnd[0]) ? mem_word(base) : (mem_word(base) & 32'h0000_FFFF);
				chk(pop_data[v], m);
				chk(sp[v], base + n);
			end
			run(mk(OP_PUSH_ERR, 1'b1, 1'b1, base, {rnd, rnd}));
			for (int v = 0; v < 3; v++)
			begin
				leg = (v == 2);
				chk(32'(wr_be[v]), leg ? 32'(BE_LO16) : 32'(BE_ALL));
				chk(32'(wr_data[v][15:0]), 32'(rnd));
				if (!leg) chk(wr_data[v], {16'h0000, rnd});
				chk(sp[v], base - ERR_STEP);
			end
		end
		// wide selector push and pop whose upper bytes are out of reach
		for (int i = 0; i < 2; i++)
		begin
			c = mk(i == 0 ? OP_PUSH_SEL : OP_POP_SEL, 1'b1, 1'b1, 32'h0000_1000, 32'h0000_0042);
			c.upper_ok = 1'b0;
			run(c);
			for (int v = 0; v < 3; v++)
			begin
				alt = (v == 1);
				chk(32'(exc[v]), alt ? 32'(EXC_SEG) : 32'(EXC_NONE));
				chk(wr_count[v], (alt || i == 1) ? cnt[v] : cnt[v] + 32'h1);
				m = (i == 0) ? 32'h0000_0FFC : 32'h0000_1004;
				chk(sp[v], alt ? 32'h0000_1000 : m);
			end
		end
		// wrapping pops to memory, both operand sizes, small real-mode segment then large protected segment
		for (int i = 0; i < 4; i++)
		begin
			base = {16'h0000, i[0] ? SP_WRAP_DWORD : SP_WRAP_WORD};
			c = mk(OP_POP_MEM, i[0], 1'b0, base, 32'h0);
			c.sp_base = 1'b1;
			c.prot_mode = i[1];
			c.ss_big = i[1];
			c.ea_off = 32'h0000_0010;
			run(c);
			m = i[0] ? mem_word(base) : (mem_word(base) & 32'h0000_FFFF);
			for (int v = 0; v < 3; v++)
			begin
				alt = (v == 1);
				chk(32'(exc[v]), (alt && !i[1]) ? 32'(EXC_STACK) : 32'(EXC_NONE));
				chk(wr_count[v], (alt && !i[1]) ? cnt[v] : cnt[v] + 32'h1);
				if (!(alt && !i[1]))
				begin
					chk(wr_addr[v], alt ? 32'h0001_0010 : 32'h0000_0010);
					chk(wr_data[v], m);
					chk(sp[v], 32'h0000_0000);
				end
			end
		end
		// far calls: limit fault, rights fault, then a clean one
		for (int i = 0; i < 3; i++)
		begin
			c = mk(OP_FAR_CALL, 1'b1, 1'b1, 32'h0000_2000, 32'h0000_1234);
			c.br_limit_viol = i == 0;
			c.br_rights_viol = i == 1;
			run(c);
			for (int v = 0; v < 3; v++)
			begin
				chk(32'(exc[v]), i < 2 ? 32'(EXC_BRANCH) : 32'(EXC_NONE));
				chk(wr_count[v], i < 2 ? cnt[v] : cnt[v] + 32'h2);
				chk(sp[v], i < 2 ? 32'h0000_2000 : 32'h0000_1FF8);
				if (i == 2) chk(wr_data[v], ~32'h0000_1234);
			end
		end
		run(mk(OP_RET_GATE16, 1'b0, 1'b1, 32'h0003_0040, 32'h0));
		for (int v = 0; v < 3; v++)
			chk(sp[v], mem_word(32'h0003_0040) & 32'h0000_FFFF);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
